//--- bos_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module bos_conv_model
    import bos_pkg::*;
(
    // clock
    input wire logic pclk,
    // reading towards the block
    output logic rd_valid,
    output logic signed [CNT_W-1:0] rd_counts,
    output logic [RANGE_W-1:0] rd_range,
    output logic [RES_W-1:0] rd_res
);
    // idle at time zero
    initial begin
        rd_valid = 1'b0;
        rd_counts = '0;
        rd_range = '0;
        rd_res = '0;
    end
    // one result pulse after gap idle cycles, data scrambled once it ends
    task automatic convert(input logic signed [CNT_W-1:0] c, input logic [RANGE_W-1:0] rg,
                           input logic [RES_W-1:0] rs, input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        rd_valid <= 1'b1;
        rd_counts <= c;
        rd_range <= rg;
        rd_res <= rs;
        @(posedge pclk);
        rd_valid <= 1'b0;
        rd_counts <= ~c;
        rd_range <= ~rg;
        rd_res <= ~rs;
    endtask : convert
endmodule : bos_conv_model
`default_nettype wire

//--- bos_pkg.sv
// Summary of operation
// - Enabling takes the shown reading as baseline; later results are input minus baseline.
// - Each measurement function keeps its own baseline, untouched by switching functions.
// - A baseline keeps its absolute value on ranges of its function up to three decades below its own; lower, a nonzero one is overrange.
// - A baseline magnitude up to the half-range count of the highest resolution is accepted.
// - Results are limited to half the count range, or to the full range with suppression on.
// - Every count limit drops by ten for each resolution step below the highest.
// - Overrange is judged on the raw input reading and also on the rescaled baseline and the suppressed result.
// - The key toggles; disabling clears the indicator and only the selected baseline.
// - Each captured baseline is copied into the offset program store, which survives a disable.
// - A new baseline needs disable then enable and comes from the first on-scale conversion after it.
// - A range more than three decades below a nonzero stored baseline, or one that rescales it past half range, gives the overrange indication.
// - The indicator blinks until an on-scale baseline reading is taken, then stays lit.
// - The baseline loads either from an applied input or from the offset program store.
`default_nettype none
package bos_pkg;
    localparam int CNT_W = 25;
    localparam int WIDE_W = 48;
    localparam int EXP_W = 4;
    localparam int RANGE_W = 3;
    localparam int RES_W = 2;
    localparam int FUNC_W = 3;
    localparam int NUM_FUNC = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // count limits at the highest resolution
    localparam logic signed [WIDE_W-1:0] HALF_LIM_TOP = 48'sd3030000;
    localparam logic signed [WIDE_W-1:0] FULL_LIM_TOP = 48'sd6060000;
    localparam logic signed [WIDE_W-1:0] DEC_STEP = 48'sd10;
    localparam int RES_STEPS = 3;
    localparam logic [EXP_W-1:0] MAX_DOWN = 4'h7;
    localparam logic [EXP_W-1:0] MAX_UP = 4'h3;
    // function select codes
    localparam logic [FUNC_W-1:0] FN_DC_VOLTS = 3'h0;
    localparam logic [FUNC_W-1:0] FN_AC_VOLTS = 3'h1;
    localparam logic [FUNC_W-1:0] FN_RESISTANCE = 3'h2;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CLR = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IEN = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PROG = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h18;
    // field positions
    localparam int CT_KEY = 0;
    localparam int CT_RECALL = 1;
    localparam int ST_CAP = 0;
    localparam int ST_OVR = 1;
    localparam int ST_REJ = 2;
    localparam int STAT_W = 3;
    localparam int PROG_EXP_LSB = 25;
    localparam int RES_OVR_BIT = 25;
    localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
    // indicator blink half period
    localparam int BLINK_HALF_MS = 250;
    localparam longint CLK_HZ = 40000000;
    localparam int BLINK_HALF_CYC = int'((CLK_HZ * BLINK_HALF_MS) / 1000);
    localparam int BLINK_W = 24;

    typedef enum logic [1:0] {
        ZS_OFF = 2'b00,
        ZS_WAIT = 2'b01,
        ZS_ON = 2'b10
    } bos_zstate_t;

    // ten to the power d
    function automatic logic signed [WIDE_W-1:0] bos_pow10(input logic [EXP_W-1:0] d);
        logic signed [WIDE_W-1:0] v;
        v = 48'sd1;
        for (int i = 0; i < 16; i++) begin
            if (i < int'(d)) v = v * DEC_STEP;
        end
        return v;
    endfunction : bos_pow10

    // count limit for a resolution, half or full range
    function automatic logic signed [WIDE_W-1:0] bos_limit(input logic [RES_W-1:0] res,
                                                           input logic full);
        logic signed [WIDE_W-1:0] v;
        v = full ? FULL_LIM_TOP : HALF_LIM_TOP;
        for (int i = 0; i < RES_STEPS; i++) begin
            if (i < int'(res)) v = v / DEC_STEP;
        end
        return v;
    endfunction : bos_limit

    function automatic logic signed [WIDE_W-1:0] bos_abs(input logic signed [WIDE_W-1:0] x);
        return (x < 0) ? -x : x;
    endfunction : bos_abs
endpackage : bos_pkg
`default_nettype wire

//--- bos_top.sv
`timescale 1ns/1ps
`default_nettype none
module bos_top
    import bos_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter readings
    input wire logic rd_valid,
    input wire logic signed [CNT_W-1:0] rd_counts,
    input wire logic [RANGE_W-1:0] rd_range,
    input wire logic [RES_W-1:0] rd_res,
    // front panel function select
    input wire logic [FUNC_W-1:0] func_sel,
    // display side
    output logic out_valid,
    output logic signed [CNT_W-1:0] out_counts,
    output logic out_ovr,
    output logic zero_ind,
    output logic irq
);
    bos_zstate_t zs_mem [NUM_FUNC];
    logic signed [CNT_W-1:0] base_mem [NUM_FUNC];
    logic [EXP_W-1:0] bexp_mem [NUM_FUNC];
    logic signed [CNT_W-1:0] prog_val_reg;
    logic [EXP_W-1:0] prog_exp_reg;
    logic [STAT_W-1:0] stat_reg;
    logic [STAT_W-1:0] ien_reg;
    logic key_reg;
    logic recall_reg;
    logic [BLINK_W-1:0] blink_cnt_reg;
    logic blink_ph_reg;
    logic wr_go;
    logic rd_go;
    logic fsel_ok;
    logic [FUNC_W-1:0] fidx;
    bos_zstate_t zs_cur;
    logic [EXP_W-1:0] now_exp;
    logic signed [CNT_W-1:0] diff;
    logic dp_ovr;
    logic onscale;
    logic cap_go;
    logic prog_bad;
    logic [DATA_W-1:0] rd_mux;
    logic [STAT_W-1:0] stat_set;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    function automatic logic bos_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFS_CTRL) || (a == OFS_STATE) || (a == OFS_STAT) || (a == OFS_CLR)
            || (a == OFS_IEN) || (a == OFS_PROG) || (a == OFS_RESULT);
    endfunction : bos_mapped

    // selected function and decade weight of the reading
    assign fsel_ok = (func_sel < FUNC_W'(NUM_FUNC));
    assign fidx = fsel_ok ? func_sel : FN_DC_VOLTS;
    assign zs_cur = zs_mem[fidx];
    assign now_exp = EXP_W'(rd_range) + EXP_W'(rd_res);
    assign onscale = bos_abs(WIDE_W'(rd_counts)) <= bos_limit(rd_res, 1'b0);
    assign cap_go = rd_valid && fsel_ok && (zs_cur == ZS_WAIT) && onscale && !key_reg;
    assign prog_bad = bos_abs(WIDE_W'($signed(pwdata[CNT_W-1:0]))) > HALF_LIM_TOP;

    // apb handshake: one wait state, writes land on the pready edge
    assign wr_go = psel && penable && pwrite && pready;
    assign rd_go = psel && penable && !pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= rd_go;
            if (rd_go) begin
                pslverr <= !bos_mapped(paddr);
                prdata <= pwrite ? '0 : rd_mux;
            end
        end
    end

    // read data decode
    always_comb begin
        rd_mux = '0;
        if (paddr == OFS_STATE) begin
            rd_mux = {29'h0, zero_ind, zs_cur};
        end else if (paddr == OFS_STAT) begin
            rd_mux = {29'h0, stat_reg};
        end else if (paddr == OFS_IEN) begin
            rd_mux = {29'h0, ien_reg};
        end else if (paddr == OFS_PROG) begin
            rd_mux = {3'h0, prog_exp_reg, prog_val_reg};
        end else if (paddr == OFS_RESULT) begin
            rd_mux = {6'h0, out_ovr, out_counts};
        end
    end

    // command pulses and interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_reg <= 1'b0;
            recall_reg <= 1'b0;
            ien_reg <= STAT_RST;
        end else begin
            key_reg <= wr_go && (paddr == OFS_CTRL) && pwdata[CT_KEY];
            recall_reg <= wr_go && (paddr == OFS_CTRL) && pwdata[CT_RECALL];
            if (wr_go && (paddr == OFS_IEN)) ien_reg <= pwdata[STAT_W-1:0];
        end
    end

    // offset program store: software write or baseline copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_val_reg <= '0;
            prog_exp_reg <= '0;
        end else if (cap_go) begin
            prog_val_reg <= rd_counts;
            prog_exp_reg <= now_exp;
        end else if (wr_go && (paddr == OFS_PROG) && !prog_bad) begin
            prog_val_reg <= pwdata[CNT_W-1:0];
            prog_exp_reg <= pwdata[PROG_EXP_LSB +: EXP_W];
        end
    end

    // per-function suppression state and baselines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_FUNC; i++) begin
                zs_mem[i] <= ZS_OFF;
                base_mem[i] <= '0;
                bexp_mem[i] <= '0;
            end
        end else if (fsel_ok) begin
            case (zs_cur)
                ZS_OFF: begin
                    if (recall_reg) begin
                        zs_mem[fidx] <= ZS_ON;
                        base_mem[fidx] <= prog_val_reg;
                        bexp_mem[fidx] <= prog_exp_reg;
                    end else if (key_reg) begin
                        zs_mem[fidx] <= ZS_WAIT;
                    end
                end
                ZS_WAIT: begin
                    if (key_reg) begin
                        zs_mem[fidx] <= ZS_OFF;
                    end else if (cap_go) begin
                        zs_mem[fidx] <= ZS_ON;
                        base_mem[fidx] <= rd_counts;
                        bexp_mem[fidx] <= now_exp;
                    end
                end
                ZS_ON: begin
                    if (key_reg) begin
                        zs_mem[fidx] <= ZS_OFF;
                        base_mem[fidx] <= '0;
                        bexp_mem[fidx] <= '0;
                    end
                end
                default: zs_mem[fidx] <= ZS_OFF;
            endcase
        end
    end

    // subtract stage
    bos_zsub u_zsub (
        .raw(rd_counts),
        .now_exp(now_exp),
        .res(rd_res),
        .base(base_mem[fidx]),
        .base_exp(bexp_mem[fidx]),
        .zero_on(zs_cur == ZS_ON),
        .diff(diff),
        .ovr(dp_ovr)
    );

    // result register toward the display
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_counts <= '0;
            out_ovr <= 1'b0;
        end else begin
            out_valid <= rd_valid;
            if (rd_valid) begin
                out_counts <= (zs_cur == ZS_WAIT) ? rd_counts : diff;
                out_ovr <= dp_ovr;
            end
        end
    end

    // blink divider: phase toggles each half period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_reg <= '0;
            blink_ph_reg <= 1'b0;
        end else if (blink_cnt_reg == BLINK_W'(BLINK_CYC - 1)) begin
            blink_cnt_reg <= '0;
            blink_ph_reg <= !blink_ph_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 1'b1;
        end
    end

    // suppression indicator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_ind <= 1'b0;
        end else begin
            case (zs_cur)
                ZS_WAIT: zero_ind <= blink_ph_reg;
                ZS_ON: zero_ind <= 1'b1;
                default: zero_ind <= 1'b0;
            endcase
        end
    end

    // sticky status, set wins over clear
    assign stat_set = {wr_go && (paddr == OFS_PROG) && prog_bad, rd_valid && dp_ovr, cap_go};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= STAT_RST;
        end else if (wr_go && (paddr == OFS_CLR)) begin
            stat_reg <= (stat_reg & ~pwdata[STAT_W-1:0]) | stat_set;
        end else begin
            stat_reg <= stat_reg | stat_set;
        end
    end

    // level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_reg & ien_reg);
        end
    end

    // checks
    property p_capture;
        cap_go |=> (zs_mem[$past(fidx)] == ZS_ON) && (base_mem[$past(fidx)] == $past(rd_counts));
    endproperty
    a_capture: assert property (p_capture) else $error("baseline not captured");

    property p_keep_other;
        (fidx != FN_DC_VOLTS) |=> $stable(base_mem[0]) && $stable(zs_mem[0]);
    endproperty
    a_keep_other: assert property (p_keep_other) else $error("other function disturbed");

    property p_prog_limit;
        (wr_go && (paddr == OFS_PROG) && prog_bad && !cap_go) |=> $stable(prog_val_reg)
            && stat_reg[ST_REJ];
    endproperty
    a_prog_limit: assert property (p_prog_limit) else $error("oversize baseline accepted");

    property p_off_limit;
        (rd_valid && (zs_cur == ZS_OFF) && !onscale)
            |=> out_ovr;
    endproperty
    a_off_limit: assert property (p_off_limit) else $error("half range not enforced");

    property p_raw_ovr;
        (rd_valid && !onscale) |=> out_ovr && out_valid;
    endproperty
    a_raw_ovr: assert property (p_raw_ovr) else $error("raw overrange missed");

    property p_key_off;
        (key_reg && fsel_ok && (zs_cur == ZS_ON)) |=> (zs_mem[$past(fidx)] == ZS_OFF)
            && (base_mem[$past(fidx)] == '0) ##1 !zero_ind;
    endproperty
    a_key_off: assert property (p_key_off) else $error("disable did not clear");

    property p_prog_copy;
        cap_go |=> (prog_val_reg == $past(rd_counts)) && (prog_exp_reg == $past(now_exp));
    endproperty
    a_prog_copy: assert property (p_prog_copy) else $error("store not updated");

    property p_wait_first;
        (zs_cur == ZS_WAIT) && !rd_valid && !key_reg |=> (zs_mem[$past(fidx)] == ZS_WAIT);
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("captured without reading");

    property p_lit;
        (zs_cur == ZS_ON) && $stable(func_sel) |=> zero_ind;
    endproperty
    a_lit: assert property (p_lit) else $error("indicator not lit");

    property p_result_bound;
        out_valid && !out_ovr |-> bos_abs(WIDE_W'(out_counts)) <= FULL_LIM_TOP;
    endproperty
    a_result_bound: assert property (p_result_bound) else $error("result beyond range");

    property p_irq;
        |(stat_reg & ien_reg) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    // raw display while waiting, recall, indicator, store and bus pulse
    property p_wait_raw;
        rd_valid && (zs_cur == ZS_WAIT)
            |=> out_valid && (out_counts == $past(rd_counts));
    endproperty
    a_wait_raw: assert property (p_wait_raw) else $error("waiting reading not shown raw");

    property p_recall;
        (recall_reg && fsel_ok && (zs_cur == ZS_OFF)) |=> (zs_mem[$past(fidx)] == ZS_ON)
            && (base_mem[$past(fidx)] == $past(prog_val_reg));
    endproperty
    a_recall: assert property (p_recall) else $error("program value not recalled");

    property p_ind_off;
        (zs_cur == ZS_OFF) |=> !zero_ind;
    endproperty
    a_ind_off: assert property (p_ind_off) else $error("indicator lit while off");

    property p_prog_keep;
        (key_reg && (zs_cur == ZS_ON) && !wr_go)
            |=> $stable(prog_val_reg) && $stable(prog_exp_reg);
    endproperty
    a_prog_keep: assert property (p_prog_keep) else $error("store lost on disable");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

    c_capture: cover property (cap_go);
    c_recall: cover property (recall_reg && (zs_cur == ZS_OFF) ##1 (zs_cur == ZS_ON));
    c_disable: cover property (key_reg && (zs_cur == ZS_ON));
    c_ovr: cover property (rd_valid && dp_ovr && (zs_cur == ZS_ON));
    c_reject: cover property (wr_go && (paddr == OFS_PROG) && prog_bad);
endmodule : bos_top
`default_nettype wire

//--- bos_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bos_top_tb_top
    import bos_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic rd_valid;
    logic signed [CNT_W-1:0] rd_counts;
    logic [RANGE_W-1:0] rd_range;
    logic [RES_W-1:0] rd_res;
    logic [FUNC_W-1:0] func_sel;
    logic out_valid;
    logic signed [CNT_W-1:0] out_counts;
    logic out_ovr;
    logic zero_ind;
    logic irq;
    logic [DATA_W-1:0] rdat;
    logic rerr;
    logic signed [CNT_W-1:0] hl;
    logic signed [CNT_W-1:0] fl;
    int n_errors;
    int cmp_count;

    // block under test with a short blink period
    bos_top #(.BLINK_CYC(4)) u_bos_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rd_valid(rd_valid), .rd_counts(rd_counts),
        .rd_range(rd_range), .rd_res(rd_res), .func_sel(func_sel),
        .out_valid(out_valid), .out_counts(out_counts), .out_ovr(out_ovr),
        .zero_ind(zero_ind), .irq(irq)
    );
    // converter side
    bos_conv_model u_bos_conv_model (
        .pclk(pclk), .rd_valid(rd_valid), .rd_counts(rd_counts),
        .rd_range(rd_range), .rd_res(rd_res)
    );

    // 40 mhz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic close_out;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(1'b0, 1'b1, "no pready");
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string s);
        apb(1'b0, a, '0);
        chk(rdat, e, s);
    endtask : rd

    task automatic sel(input logic [FUNC_W-1:0] f);
        @(posedge pclk);
        func_sel <= f;
    endtask : sel

    // one reading, result judged in its out_valid cycle
    task automatic conv(input logic signed [CNT_W-1:0] c, input logic [RANGE_W-1:0] rg,
                        input logic [RES_W-1:0] rs, input logic signed [CNT_W-1:0] e,
                        input logic eo, input logic ck);
        u_bos_conv_model.convert(c, rg, rs, 0);
        #1;
        chk(out_valid, 1'b1, "valid");
        chk(out_ovr, eo, "ovr");
        if (ck) chk(out_counts, e, "counts");
    endtask : conv

    // counts indicator high and low samples
    task automatic watch(output int hi, output int lo);
        hi = 0;
        lo = 0;
        repeat (16) begin
            @(posedge pclk);
            #1;
            if (zero_ind === 1'b1) hi++;
            else lo++;
        end
    endtask : watch

    task automatic t_reset;
        rd(OFS_STATE, '0, "state");
        rd(OFS_STAT, '0, "stat");
        rd(OFS_IEN, '0, "ien");
        rd(OFS_PROG, '0, "prog");
        rd(8'h1c, '0, "unmapped");
        chk(rerr, 1'b1, "slverr");
    endtask : t_reset

    // limits at every resolution with suppression off
    task automatic t_limits;
        logic signed [CNT_W-1:0] lim;
        lim = hl;
        for (int r = 0; r < 4; r++) begin
            conv(lim, 3'h2, r[RES_W-1:0], lim, 1'b0, 1'b1);
            conv(-lim - 25'sh1, 3'h2, r[RES_W-1:0], '0, 1'b1, 1'b0);
            lim = lim / 25'sha;
        end
    endtask : t_limits

    task automatic t_capture;
        int hi;
        int lo;
        wr_clr: apb(1'b1, OFS_CLR, 32'h7);
        apb(1'b1, OFS_IEN, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_STATE, '0);
        chk(rdat[1:0], 2'h1, "waiting");
        watch(hi, lo);
        chk(hi > 0 && lo > 0, 1'b1, "blink");
        conv(hl + 25'sh1, 3'h2, 2'h0, '0, 1'b1, 1'b0);
        apb(1'b0, OFS_STATE, '0);
        chk(rdat[1:0], 2'h1, "still waiting");
        conv(25'sh3e8, 3'h2, 2'h0, 25'sh3e8, 1'b0, 1'b1);
        watch(hi, lo);
        chk(lo, 0, "steady");
        rd(OFS_STAT, 32'h3, "stat");
        chk(irq, 1'b1, "irq");
        rd(OFS_PROG, {3'h0, 4'h2, 25'sh3e8}, "prog copy");
        conv(25'sh5dc, 3'h2, 2'h0, 25'sh1f4, 1'b0, 1'b1);
        rd(OFS_RESULT, {6'h0, 1'b0, 25'sh1f4}, "result");
        apb(1'b1, OFS_IEN, 32'h0);
        rd(OFS_IEN, '0, "ien");
        chk(irq, 1'b0, "masked");
        apb(1'b1, OFS_CLR, 32'h7);
        rd(OFS_STAT, '0, "cleared");
    endtask : t_capture

    task automatic t_func;
        sel(FN_AC_VOLTS);
        apb(1'b1, OFS_CTRL, 32'h1);
        conv(25'shc8, 3'h2, 2'h0, 25'shc8, 1'b0, 1'b1);
        sel(FN_DC_VOLTS);
        conv(25'sh96, 3'h3, 2'h0, 25'sh32, 1'b0, 1'b1);
        sel(FN_AC_VOLTS);
        conv(25'sh2bc, 3'h2, 2'h0, 25'sh1f4, 1'b0, 1'b1);
        sel(FN_RESISTANCE);
        apb(1'b1, OFS_CTRL, 32'h1);
        conv(hl, 3'h2, 2'h0, hl, 1'b0, 1'b1);
        conv(25'sh5, 3'h1, 2'h0, '0, 1'b1, 1'b0);
        conv(hl, 3'h2, 2'h0, '0, 1'b0, 1'b1);
    endtask : t_func

    task automatic t_full;
        sel(3'h3);
        apb(1'b1, OFS_CTRL, 32'h1);
        conv(-hl, 3'h2, 2'h0, -hl, 1'b0, 1'b1);
        conv(hl, 3'h2, 2'h0, fl, 1'b0, 1'b1);
        conv(-hl, 3'h2, 2'h0, '0, 1'b0, 1'b1);
        conv(-hl - 25'sh1, 3'h2, 2'h0, '0, 1'b1, 1'b0);
    endtask : t_full

    task automatic t_off;
        sel(FN_DC_VOLTS);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_STATE, '0);
        chk(rdat[2:0], 3'h0, "off");
        chk(zero_ind, 1'b0, "ind off");
        conv(25'sh5dc, 3'h2, 2'h0, 25'sh5dc, 1'b0, 1'b1);
        sel(FN_AC_VOLTS);
        conv(25'sh2bc, 3'h2, 2'h0, 25'sh1f4, 1'b0, 1'b1);
        sel(FN_DC_VOLTS);
        apb(1'b1, OFS_CTRL, 32'h2);
        conv('0, 3'h2, 2'h0, hl, 1'b0, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_PROG, {3'h0, 4'h2, 25'sh190});
        rd(OFS_PROG, {3'h0, 4'h2, 25'sh190}, "prog");
        apb(1'b1, OFS_PROG, {3'h0, 4'h2, hl + 25'sh1});
        rd(OFS_PROG, {3'h0, 4'h2, 25'sh190}, "prog kept");
        apb(1'b0, OFS_STAT, '0);
        chk(rdat[ST_REJ], 1'b1, "rejected");
        apb(1'b1, OFS_CTRL, 32'h2);
        conv(25'sh3e8, 3'h2, 2'h0, 25'sh258, 1'b0, 1'b1);
    endtask : t_off

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        close_out();
    end

    // main sequence
    initial begin
        n_errors = 0;
        cmp_count = 0;
        hl = HALF_LIM_TOP[CNT_W-1:0];
        fl = FULL_LIM_TOP[CNT_W-1:0];
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        func_sel = FN_DC_VOLTS;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_limits();
        t_capture();
        t_func();
        t_full();
        t_off();
        close_out();
    end
endmodule : bos_top_tb_top
`default_nettype wire

//--- bos_zsub.sv
`timescale 1ns/1ps
`default_nettype none
module bos_zsub
    import bos_pkg::*;
(
    // reading and its decade weight
    input wire logic signed [CNT_W-1:0] raw,
    input wire logic [EXP_W-1:0] now_exp,
    input wire logic [RES_W-1:0] res,
    // stored baseline
    input wire logic signed [CNT_W-1:0] base,
    input wire logic [EXP_W-1:0] base_exp,
    input wire logic zero_on,
    // result
    output logic signed [CNT_W-1:0] diff,
    output logic ovr
);
    logic signed [WIDE_W-1:0] scaled;
    logic signed [WIDE_W-1:0] wide_diff;
    logic signed [WIDE_W-1:0] half_lim;
    logic signed [WIDE_W-1:0] act_lim;
    logic too_big;

    // rescale baseline to the present range and resolution
    always_comb begin
        scaled = '0;
        too_big = 1'b0;
        if (!zero_on) begin
            scaled = '0;
        end else if (now_exp >= base_exp) begin
            if (now_exp - base_exp <= MAX_DOWN) begin
                scaled = WIDE_W'(base) / bos_pow10(now_exp - base_exp);
            end
        end else if (base_exp - now_exp > MAX_UP) begin
            too_big = (base != '0);
        end else begin
            scaled = WIDE_W'(base) * bos_pow10(base_exp - now_exp);
        end
    end

    // subtract and judge overrange
    always_comb begin
        half_lim = bos_limit(res, 1'b0);
        act_lim = bos_limit(res, zero_on);
        wide_diff = WIDE_W'(raw) - scaled;
        ovr = too_big
            || (bos_abs(WIDE_W'(raw)) > half_lim)
            || (bos_abs(scaled) > half_lim)
            || (bos_abs(wide_diff) > act_lim);
        diff = wide_diff[CNT_W-1:0];
    end
endmodule : bos_zsub
`default_nettype wire
